// File: hw/qpt_core.sv
// quad phase fetch/execute timing and two stage pipeline
// assumes asynchronous program memory data and register file read data
// Functional notes
// - clock divided into four sequential phases
// - program counter increments in phase one
// - fetched word captured at phase four
// - decode and execute during phases two-four
// - operand read in phase two
// - result written in phase four
// - fetch overlaps execute, one per cycle
// - jumps take two instruction cycles
// - branch discards prefetched word, fetches target
// - oscillator pin is port bit five only in rc
// - fetching starts at address zero after reset
`timescale 1ns/100ps
module qpt_core
    import qpt_pkg::*;
#(
    parameter int PC_W = `QPT_PC_W,
    parameter int INSN_W = `QPT_INSN_W,
    parameter int DATA_W = `QPT_DATA_W
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [`QPT_OSC_MODE_W-1:0] OSC_MODE,
    input wire logic OSC_PIN_IN,
    input wire logic PORT_BIT_FIVE_OUT,
    input wire logic PORT_BIT_FIVE_OE,
    input wire logic [INSN_W-1:0] PMEM_RDATA,
    input wire logic [DATA_W-1:0] DMEM_RDATA,
    output logic [PC_W-1:0] PMEM_ADDR,
    output logic DMEM_RD_EN,
    output logic DMEM_WR_EN,
    output logic [`QPT_ADDR_W-1:0] DMEM_ADDR,
    output logic [DATA_W-1:0] DMEM_WDATA,
    output logic [1:0] PHASE,
    output logic INSN_DONE,
    output logic FLUSH,
    output logic PORT_BIT_FIVE_IN,
    output logic OSC_PIN_OUT,
    output logic OSC_PIN_OE,
    output logic CLK_IN_SEL
);
    // instruction format of this core:
    // [11] jump, [10] write enable, [9:5] dst, [4:0] src
    // for a jump, [9:0] hold the target address
    function automatic qpt_decode_t decode(input logic [INSN_W-1:0] w);
        qpt_decode_t d;
        d.is_jump = w[INSN_W-1];
        d.writes = w[INSN_W-2] & ~w[INSN_W-1];
        d.dst = w[2*`QPT_ADDR_W-1:`QPT_ADDR_W];
        d.src = w[`QPT_ADDR_W-1:0];
        return d;
    endfunction

    qpt_phase_t phase;

    // phase four is decoded locally, so the end-of-cycle flag is unused
    qpt_phase_gen u_phase (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .phase(phase),
        .cycle_end()
    );

    logic [PC_W-1:0] pc_q, pc_d;
    logic [INSN_W-1:0] fetch_q, fetch_d;
    logic fetch_vld_q, fetch_vld_d;
    logic [INSN_W-1:0] exec_q, exec_d;
    logic exec_vld_q, exec_vld_d;
    logic [DATA_W-1:0] operand_q, operand_d;
    logic jump_pend_q, jump_pend_d;
    logic [PC_W-1:0] target_q, target_d;
    qpt_decode_t dec;
    qpt_decode_t dec_nx;

    assign dec = decode(exec_q);
    // view of the word about to execute, for the phase two read strobe
    assign dec_nx = decode(exec_d);

    // pipeline state
    always_comb begin
        pc_d = pc_q;
        fetch_d = fetch_q;
        fetch_vld_d = fetch_vld_q;
        exec_d = exec_q;
        exec_vld_d = exec_vld_q;
        operand_d = operand_q;
        jump_pend_d = jump_pend_q;
        target_d = target_q;
        case (phase)
            PH_ONE: begin
                // captured word becomes the executing one
                exec_d = fetch_q;
                exec_vld_d = fetch_vld_q;
                if (jump_pend_q) begin
                    pc_d = target_q;
                    jump_pend_d = 1'b0;
                end else begin
                    pc_d = pc_q + 1'b1;
                end
            end
            PH_TWO: begin
                if (exec_vld_q) begin
                    operand_d = DMEM_RDATA;
                end
            end
            PH_THREE: begin
                if (exec_vld_q && dec.is_jump) begin
                    target_d = PC_W'(exec_q[INSN_W-3:0]);
                    jump_pend_d = 1'b1;
                end
            end
            PH_FOUR: begin
                if (jump_pend_q) begin
                    // prefetched word is dropped, slot runs as a nop
                    fetch_d = `QPT_NOP_WORD;
                    fetch_vld_d = 1'b0;
                end else begin
                    fetch_d = PMEM_RDATA;
                    fetch_vld_d = 1'b1;
                end
            end
            default: begin
                pc_d = pc_q;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            // pc holds one below zero so the first phase one fetches 0
            pc_q <= {PC_W{1'b1}};
            fetch_q <= `QPT_NOP_WORD;
            fetch_vld_q <= 1'b0;
            exec_q <= `QPT_NOP_WORD;
            exec_vld_q <= 1'b0;
            operand_q <= '0;
            jump_pend_q <= 1'b0;
            target_q <= `QPT_RESET_VECTOR;
        end else begin
            pc_q <= pc_d;
            fetch_q <= fetch_d;
            fetch_vld_q <= fetch_vld_d;
            exec_q <= exec_d;
            exec_vld_q <= exec_vld_d;
            operand_q <= operand_d;
            jump_pend_q <= jump_pend_d;
            target_q <= target_d;
        end
    end

    // registered outputs, computed one edge ahead of the phase they mark
    qpt_phase_t next_phase;
    qpt_dmem_t dmem_d, dmem_q;
    logic done_d, done_q, flush_d, flush_q;
    logic rc_mode;

    always_comb begin
        case (phase)
            PH_ONE: next_phase = PH_TWO;
            PH_TWO: next_phase = PH_THREE;
            PH_THREE: next_phase = PH_FOUR;
            PH_FOUR: next_phase = PH_ONE;
            default: next_phase = PH_ONE;
        endcase
        dmem_d = '0;
        dmem_d.addr = dec.src;
        done_d = 1'b0;
        flush_d = 1'b0;
        // read strobe stands through phase two of a live slot
        if (next_phase == PH_TWO && exec_vld_d) begin
            dmem_d.rd_en = 1'b1;
            dmem_d.addr = dec_nx.src;
        end
        if (next_phase == PH_FOUR && exec_vld_q && dec.writes) begin
            dmem_d.wr_en = 1'b1;
            dmem_d.addr = dec.dst;
            dmem_d.wdata = operand_q;
        end
        if (next_phase == PH_FOUR && exec_vld_q && !dec.is_jump) begin
            done_d = 1'b1;
        end
        if (next_phase == PH_FOUR && jump_pend_d) begin
            flush_d = 1'b1;
        end
        // no completion is flagged for a jump or for its flushed slot
        if (next_phase == PH_FOUR && !exec_vld_q && jump_pend_q == 1'b0
            && fetch_vld_q == 1'b0 && exec_q == `QPT_NOP_WORD) begin
            done_d = 1'b0;
        end
    end

    assign rc_mode = (OSC_MODE == `QPT_OSC_INT_RC);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            dmem_q <= '0;
            done_q <= 1'b0;
            flush_q <= 1'b0;
            PORT_BIT_FIVE_IN <= 1'b0;
            OSC_PIN_OUT <= 1'b0;
            OSC_PIN_OE <= 1'b0;
            CLK_IN_SEL <= 1'b1;
        end else begin
            dmem_q <= dmem_d;
            done_q <= done_d;
            flush_q <= flush_d;
            // pin is general i/o only in internal rc mode
            PORT_BIT_FIVE_IN <= rc_mode & OSC_PIN_IN;
            OSC_PIN_OUT <= rc_mode & PORT_BIT_FIVE_OUT;
            OSC_PIN_OE <= rc_mode & PORT_BIT_FIVE_OE;
            CLK_IN_SEL <= ~rc_mode;
        end
    end

    assign PMEM_ADDR = pc_q;
    assign PHASE = phase;
    assign DMEM_RD_EN = dmem_q.rd_en;
    assign DMEM_WR_EN = dmem_q.wr_en;
    assign DMEM_ADDR = dmem_q.addr;
    assign DMEM_WDATA = dmem_q.wdata;
    assign INSN_DONE = done_q;
    assign FLUSH = flush_q;
endmodule

// File: hw/qpt_phase_gen.sv
// four phase generator: divides the core clock by four
// assumes a single clock domain and an async active low reset
`timescale 1ns/100ps
module qpt_phase_gen
    import qpt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    output qpt_phase_t phase,
    output logic cycle_end
);
    qpt_phase_t phase_q, phase_d;

    always_comb begin
        case (phase_q)
            PH_ONE: phase_d = PH_TWO;
            PH_TWO: phase_d = PH_THREE;
            PH_THREE: phase_d = PH_FOUR;
            PH_FOUR: phase_d = PH_ONE;
            default: phase_d = PH_ONE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PH_ONE;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase = phase_q;
    assign cycle_end = (phase_q == PH_FOUR);
endmodule

// File: hw/qpt_pkg.sv
// types shared by the quad phase timing block
// assumes qpt_regs.svh is on the include path
`include "qpt_regs.svh"
package qpt_pkg;
    typedef enum logic [1:0] {
        PH_ONE,
        PH_TWO,
        PH_THREE,
        PH_FOUR
    } qpt_phase_t;

    // decoded view of an instruction word, built in the executor
    typedef struct packed {
        logic is_jump;
        logic writes;
        logic [`QPT_ADDR_W-1:0] dst;
        logic [`QPT_ADDR_W-1:0] src;
    } qpt_decode_t;

    // data register file access strobes
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [`QPT_ADDR_W-1:0] addr;
        logic [`QPT_DATA_W-1:0] wdata;
    } qpt_dmem_t;
endpackage

// File: hw/qpt_regs.svh
// timing constants for the quad phase fetch/execute block
// assumes a single core clock; included by its bare name
`ifndef QPT_REGS_SVH
`define QPT_REGS_SVH
`define QPT_CLK_MHZ 50
`define QPT_PHASES 4
`define QPT_RESET_VECTOR 12'h000
`define QPT_PC_W 12
`define QPT_INSN_W 12
`define QPT_DATA_W 8
`define QPT_ADDR_W 5
`define QPT_NOP_WORD 12'h000
// oscillator mode field width and internal rc code
`define QPT_OSC_MODE_W 2
`define QPT_OSC_INT_RC 2'h2
`endif

// File: tb/qpt_core_props.sv
// port checker for the quad phase core
// assumes it is bound into qpt_core; PHASE codes 0..3 are one..four
`timescale 1ns/100ps
`include "qpt_regs.svh"
module qpt_core_props #(
    parameter int PC_W = `QPT_PC_W
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [`QPT_OSC_MODE_W-1:0] OSC_MODE,
    input wire logic [PC_W-1:0] PMEM_ADDR,
    input wire logic DMEM_RD_EN,
    input wire logic DMEM_WR_EN,
    input wire logic [1:0] PHASE,
    input wire logic INSN_DONE,
    input wire logic FLUSH,
    input wire logic CLK_IN_SEL
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    property p_ph; 1'b1 |=> PHASE == $past(PHASE) + 1'b1;
    endproperty
    a_ph: assert property (p_ph)
        else $error("phase order broken");
    property p_hold; PHASE != 2'h0 |=> $stable(PMEM_ADDR);
    endproperty
    a_hold: assert property (p_hold)
        else $error("pc moved outside phase one");
    // a flush in phase four means the next phase one loads the target
    property p_inc; PHASE == 2'h0 && !$past(FLUSH)
        |=> PMEM_ADDR == $past(PMEM_ADDR) + 1'b1;
    endproperty
    a_inc: assert property (p_inc)
        else $error("pc did not step by one");
    property p_rd; DMEM_RD_EN |-> PHASE == 2'h1;
    endproperty
    a_rd: assert property (p_rd)
        else $error("operand read outside phase two");
    property p_wr; DMEM_WR_EN |-> PHASE == 2'h3 && $past(DMEM_RD_EN, 2);
    endproperty
    a_wr: assert property (p_wr)
        else $error("write not in phase four after read");
    property p_done; INSN_DONE |-> PHASE == 2'h3 && !FLUSH;
    endproperty
    a_done: assert property (p_done)
        else $error("completion outside phase four");
    property p_fl; FLUSH |-> PHASE == 2'h3
        ##1 (!INSN_DONE && !DMEM_RD_EN) [*4];
    endproperty
    a_fl: assert property (p_fl)
        else $error("dropped word was executed");
    property p_sel; 1'b1 |=> CLK_IN_SEL == ($past(OSC_MODE) != 2'h2);
    endproperty
    a_sel: assert property (p_sel)
        else $error("clock input select wrong");
    c_fl: cover property (FLUSH);
    c_wr: cover property (DMEM_WR_EN);
    c_sel: cover property (!CLK_IN_SEL);
endmodule
bind qpt_core qpt_core_props #(.PC_W(PC_W)) qpt_core_props_i (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .OSC_MODE(OSC_MODE),
    .PMEM_ADDR(PMEM_ADDR), .DMEM_RD_EN(DMEM_RD_EN),
    .DMEM_WR_EN(DMEM_WR_EN), .PHASE(PHASE), .INSN_DONE(INSN_DONE),
    .FLUSH(FLUSH), .CLK_IN_SEL(CLK_IN_SEL)
);

// File: tb/qpt_core_tb.sv
// self-checking bench for the quad phase core
// assumes the memory model and the bound port checker
`timescale 1ns/100ps
`include "qpt_regs.svh"
module qpt_core_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] osc_mode = 2'h0;
    logic ext_lvl = 1'b0;
    logic p5_out = 1'b0;
    logic p5_oe = 1'b0;
    logic [11:0] pm_rd, pm_addr;
    logic [7:0] dm_rd, wdata;
    logic [4:0] daddr;
    logic [1:0] phase;
    logic rd, wr, done, flush, p5_in, pin_out, pin_oe, clk_sel;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int dn[$];
    int fl[$];
    // the core's own drive wins over the outside source
    wire pin = pin_oe ? pin_out : ext_lvl;
    always #10 clk = ~clk;
    qpt_core qpt_core_i (
        .CORE_CLK(clk), .RST_N(rst_n), .OSC_MODE(osc_mode),
        .OSC_PIN_IN(pin), .PORT_BIT_FIVE_OUT(p5_out),
        .PORT_BIT_FIVE_OE(p5_oe), .PMEM_RDATA(pm_rd), .DMEM_RDATA(dm_rd),
        .PMEM_ADDR(pm_addr), .DMEM_RD_EN(rd), .DMEM_WR_EN(wr),
        .DMEM_ADDR(daddr), .DMEM_WDATA(wdata), .PHASE(phase),
        .INSN_DONE(done), .FLUSH(flush), .PORT_BIT_FIVE_IN(p5_in),
        .OSC_PIN_OUT(pin_out), .OSC_PIN_OE(pin_oe), .CLK_IN_SEL(clk_sel)
    );
    qpt_mem_model qpt_mem_model_i (
        .clk(clk), .pmem_addr(pm_addr), .rd_en(rd), .wr_en(wr),
        .addr(daddr), .wdata(wdata), .pmem_rdata(pm_rd),
        .dmem_rdata(dm_rd)
    );
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (done === 1'b1) dn.push_back(cyc);
        if (flush === 1'b1) fl.push_back(cyc);
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask
    task test_done;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task t_start;
        @(posedge clk) #1;
        chk("phase", phase, 2'h1);
        chk("pc", pm_addr, 12'h000);
        repeat (3) begin
            chk("slot one", {rd, wr}, 2'h0);
            @(posedge clk) #1;
        end
    endtask
    task t_pipe;
        repeat (28) @(posedge clk);
        #1;
        chk("flushes", fl.size(), 1);
        chk("before jump", (fl[0] - 4) inside {dn}, 1'b1);
        chk("dropped", (fl[0] + 4) inside {dn}, 1'b0);
        chk("target", (fl[0] + 8) inside {dn}, 1'b1);
        chk("r1", qpt_mem_model_i.rf[1], 8'h5a);
        chk("r3", qpt_mem_model_i.rf[3], 8'h03);
        chk("r5", qpt_mem_model_i.rf[5], 8'h5a);
    endtask
    task t_osc;
        p5_oe = 1'b1;
        p5_out = 1'b1;
        ext_lvl = 1'b1;
        for (int m = 0; m < 4; m++) begin
            osc_mode = 2'(m);
            repeat (3) @(posedge clk);
            #1;
            chk("clk_sel", clk_sel, m != `QPT_OSC_INT_RC);
            chk("p5_in", p5_in, m == `QPT_OSC_INT_RC);
            chk("pin_oe", pin_oe, m == `QPT_OSC_INT_RC);
            chk("pin_out", pin_out, m == `QPT_OSC_INT_RC);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        t_start;
        t_pipe;
        t_osc;
        test_done;
    end
    // the tests need about fifty cycles; a thousand leaves wide margin
    initial begin
        #20000;
        miscompares++;
        test_done;
    end
endmodule

// File: tb/qpt_mem_model.sv
// program memory and register file facing the core
// assumes reads settle within a phase; the program is fixed here
`timescale 1ns/100ps
module qpt_mem_model (
    input wire logic clk,
    input wire logic [11:0] pmem_addr,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    output logic [11:0] pmem_rdata,
    output logic [7:0] dmem_rdata
);
    logic [11:0] pm [0:15];
    logic [7:0] rf [0:31];
    initial begin
        foreach (pm[i]) pm[i] = 12'h000;
        foreach (rf[i]) rf[i] = 8'(i);
        rf[2] = 8'h5a;
        pm[0] = 12'h422;
        pm[1] = 12'h804;
        pm[2] = 12'h462;
        pm[4] = 12'h4a1;
    end
    assign pmem_rdata = pm[pmem_addr[3:0]];
    // unselected file shows the inverse so a mistimed sample is caught
    assign dmem_rdata = rd_en ? rf[addr] : ~rf[addr];
    always @(posedge clk) if (wr_en) rf[addr] <= wdata;
endmodule
